// [sles_cfg.svh]
// Offsets, field positions, reset values and timing counts of the link error supervisor.
`ifndef SLES_CFG_SVH
`define SLES_CFG_SVH
`define SLES_OFS_CTRL     4'h0
`define SLES_OFS_RETRY    4'h4
`define SLES_OFS_LOSS     4'h8
`define SLES_OFS_TERM     4'hC
`define SLES_CTRL_PAR_EN  0
`define SLES_CTRL_PAR_ODD 1
`define SLES_CTRL_DATA8   2
`define SLES_CTRL_STOP2   3
`define SLES_CTRL_TERM_LO 4
`define SLES_CTRL_TERM_HI 5
`define SLES_CTRL_CLR_TRP 6
`define SLES_CTRL_CLR_ALM 7
`define SLES_OFS_STATUS   5'h10
`define SLES_ST_TRIP      0
`define SLES_ST_ALARM     1
`define SLES_ST_LOSSRUN   2
`define SLES_ST_CODE_LO   4
`define SLES_ST_CODE_HI   7
`define SLES_ST_CNT_LO    8
`define SLES_ST_CNT_HI    21
`define SLES_RST_CTRL     6'h0C
`define SLES_RST_RETRY    14'h0000
`define SLES_RST_LOSS     14'h270F
`define SLES_RST_TERM     8'h00
`define SLES_OFF_VALUE    14'h270F
`define SLES_TERM_POS     8'h62
`define SLES_TERM_NEG     8'hC6
`define SLES_NAK_CHAR     8'h15
`define SLES_CLK_MHZ      100
`define SLES_LOSS_STEP_MS 100
`define SLES_LOSS_STEP_CYC (`SLES_LOSS_STEP_MS * 1000 * `SLES_CLK_MHZ)
`endif

// [sles_pkg.sv]
// Types shared by the link error supervisor and its receiver front end.
package sles_pkg;
  typedef logic [3:0] slesCode_t;
  // Outcome of one received request, from the frame receiver.
  typedef struct packed {
    logic paramWrite;
    logic parityErr;
    logic sumErr;
    logic protoErr;
    logic framingErr;
    logic overrunErr;
    logic charErr;
    logic instrErr;
    logic rangeErr;
  } slesReq_s;
  // Character format and terminator choice handed to the receiver.
  typedef struct packed {
    logic       parityEn;
    logic       parityOdd;
    logic       dataBits8;
    logic       stopBits2;
    logic [1:0] terminator;
  } slesLineCfg_s;
  // Reply head: acknowledge or negative acknowledge with its code digit.
  typedef struct packed {
    logic       nak;
    logic [7:0] lead;
    logic [7:0] codeChar;
  } slesReply_s;
endpackage

// [sles_supervisor.sv]
// Error classification, retry supervision and signal-loss watchdog of the serial link.
// Contract
// - Erroneous request answered with NAK and code.
// - Parity mismatch reports code 1.
// - Sum check mismatch reports code 2.
// - Syntax, timeout or terminator fault reports 3.
// - Stop bit length mismatch reports code 4.
// - Overrun reports code 5.
// - Consecutive errors beyond retry limit report 0.
// - Invalid character reports 7, no trip.
// - Parameter write in wrong mode reports A.
// - Unknown instruction B, data out of range C.
// - Codes 0 to 5 raise alarm; limit trips.
// - Codes A to C reject, drive keeps running.
// - Character has start, 7/8 data, parity, stops.
// - Request checked well inside 20 ms.
// - Count consecutive errors; beyond limit trip.
// - Retry limit 9999 never trips, raises alarm.
// - Terminal shows alarm for 98 or 198.
// - Loss of traffic trips, disables, raises alarm.
// - Loss interval 9999 disables supervision.
// - Interval 0 trips on entering link mode.
// - Any request clears the loss counter.
// - Loss timer starts at first request in mode.
// - Negative acknowledge character is 15 hex.
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "sles_cfg.svh"
module sles_supervisor #(
  parameter int LOSS_STEP_CYC = `SLES_LOSS_STEP_CYC
) (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Wishbone slave.
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [4:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Frame receiver results and the line format handed to it.
  input  wire logic                  reqDone,
  input  wire sles_pkg::slesReq_s    reqInfo,
  output sles_pkg::slesLineCfg_s     lineCfg,
  // Drive state.
  input  wire logic                  linkActive,
  input  wire logic                  cmdFromComm,
  input  wire logic                  driveRunning,
  input  wire logic                  netMode,
  // Reply and fault outputs.
  output logic                       replyValid,
  output sles_pkg::slesReply_s       replyHead,
  output logic                       comm_fault_trip,
  output logic                       driveEnable,
  output logic                       alarm_output,
  output logic                       alarmTerminal
);

  logic [5:0]  ctrl_q;
  logic [13:0] retry_limit_setting_q;
  logic [13:0] loss_check_interval_q;
  logic [7:0]  output_terminal_function_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        wrStb;
  logic        clrTrip;
  logic        clrAlarm;
  logic        trip_q;
  logic        alarm_q;
  logic [13:0] errCnt_q;
  logic [13:0] errCntInc;
  logic [3:0]  code_d;
  logic [3:0]  lastCode_q;
  logic        lineErr;
  logic        modeErr;
  logic        overLimit;
  logic        retryOff;
  logic        netMode_q;
  logic        lossArmed_q;
  logic        lossRun_q;
  logic [31:0] tick_q;
  logic [13:0] lossCnt_q;
  logic        lossTrip;
  logic        zeroTrip;
  logic        replyValid_q;
  sles_pkg::slesReply_s reply_q;

  // Digit 0..F to its ASCII character.
  function automatic logic [7:0] hexAscii(input logic [3:0] d);
    hexAscii = (d < 4'hA) ? (8'h30 + {4'h0, d}) : (8'h37 + {4'h0, d});
  endfunction

  // Same-clock bus access; the ack pulse drops the cycle after it is given.
  assign wrStb    = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
  assign clrTrip  = wrStb & (wb_adr_i == {1'b0, `SLES_OFS_CTRL}) & wb_dat_i[`SLES_CTRL_CLR_TRP];
  assign clrAlarm = wrStb & (wb_adr_i == {1'b0, `SLES_OFS_CTRL}) & wb_dat_i[`SLES_CTRL_CLR_ALM];

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // Only byte lane 0 and 1 carry fields; a write to an unmapped word is acknowledged and dropped.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q                     <= `SLES_RST_CTRL;
      retry_limit_setting_q      <= `SLES_RST_RETRY;
      loss_check_interval_q      <= `SLES_RST_LOSS;
      output_terminal_function_q <= `SLES_RST_TERM;
    end else if (wrStb) begin
      case (wb_adr_i)
        {1'b0, `SLES_OFS_CTRL}: begin
          ctrl_q <= wb_dat_i[5:0];
        end
        {1'b0, `SLES_OFS_RETRY}: begin
          if (wb_sel_i[1]) begin
            retry_limit_setting_q <= wb_dat_i[13:0];
          end
        end
        {1'b0, `SLES_OFS_LOSS}: begin
          if (wb_sel_i[1]) begin
            loss_check_interval_q <= wb_dat_i[13:0];
          end
        end
        {1'b0, `SLES_OFS_TERM}: begin
          output_terminal_function_q <= wb_dat_i[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdat_q <= 32'h00000000;
    end else begin
      rdat_q <= 32'h00000000;
      if (wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i) begin
        case (wb_adr_i)
          {1'b0, `SLES_OFS_CTRL}:  rdat_q[5:0]  <= ctrl_q;
          {1'b0, `SLES_OFS_RETRY}: rdat_q[13:0] <= retry_limit_setting_q;
          {1'b0, `SLES_OFS_LOSS}:  rdat_q[13:0] <= loss_check_interval_q;
          {1'b0, `SLES_OFS_TERM}:  rdat_q[7:0]  <= output_terminal_function_q;
          `SLES_OFS_STATUS: begin
            rdat_q[`SLES_ST_TRIP]                       <= trip_q;
            rdat_q[`SLES_ST_ALARM]                      <= alarm_q;
            rdat_q[`SLES_ST_LOSSRUN]                    <= lossRun_q;
            rdat_q[`SLES_ST_CODE_HI:`SLES_ST_CODE_LO]   <= lastCode_q;
            rdat_q[`SLES_ST_CNT_HI:`SLES_ST_CNT_LO]     <= errCnt_q;
          end
          default: rdat_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // The receiver checks framing against this format and flags any mismatch.
  assign lineCfg.parityEn   = ctrl_q[`SLES_CTRL_PAR_EN];
  assign lineCfg.parityOdd  = ctrl_q[`SLES_CTRL_PAR_ODD];
  assign lineCfg.dataBits8  = ctrl_q[`SLES_CTRL_DATA8];
  assign lineCfg.stopBits2  = ctrl_q[`SLES_CTRL_STOP2];
  assign lineCfg.terminator = ctrl_q[`SLES_CTRL_TERM_HI:`SLES_CTRL_TERM_LO];

  // Classification.
  assign lineErr   = reqInfo.parityErr | reqInfo.sumErr | reqInfo.protoErr |
                     reqInfo.framingErr | reqInfo.overrunErr;
  assign modeErr   = reqInfo.paramWrite & (~linkActive | ~cmdFromComm | driveRunning);
  assign retryOff  = (retry_limit_setting_q == `SLES_OFF_VALUE);
  assign errCntInc = (errCnt_q == 14'h3FFF) ? errCnt_q : errCnt_q + 14'h0001;
  assign overLimit = lineErr & (errCntInc > retry_limit_setting_q);

  // After the retry limit, overrun and framing come first since they make the later checks meaningless.
  always_comb begin
    code_d = 4'hF;
    if (overLimit) begin
      code_d = 4'h0;
    end else if (reqInfo.overrunErr) begin
      code_d = 4'h5;
    end else if (reqInfo.framingErr) begin
      code_d = 4'h4;
    end else if (reqInfo.parityErr) begin
      code_d = 4'h1;
    end else if (reqInfo.protoErr) begin
      code_d = 4'h3;
    end else if (reqInfo.sumErr) begin
      code_d = 4'h2;
    end else if (reqInfo.charErr) begin
      code_d = 4'h7;
    end else if (modeErr) begin
      code_d = 4'hA;
    end else if (reqInfo.instrErr) begin
      code_d = 4'hB;
    end else if (reqInfo.rangeErr) begin
      code_d = 4'hC;
    end
  end

  // The answer head leaves one cycle after the request ends, far inside every check time.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      replyValid_q <= 1'b0;
      reply_q      <= '0;
      lastCode_q   <= 4'hF;
    end else begin
      replyValid_q <= reqDone;
      if (reqDone) begin
        lastCode_q       <= code_d;
        reply_q.nak      <= (code_d != 4'hF);
        reply_q.lead     <= (code_d != 4'hF) ? `SLES_NAK_CHAR : 8'h06;
        reply_q.codeChar <= hexAscii(code_d);
      end
    end
  end

  assign replyValid = replyValid_q;
  assign replyHead  = reply_q;

  // Line errors count up; a character error holds the run, any other request without one restarts it.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      errCnt_q <= 14'h0000;
    end else if (reqDone) begin
      if (lineErr) begin
        errCnt_q <= errCntInc;
      end else if (!reqInfo.charErr) begin
        errCnt_q <= 14'h0000;
      end
    end
  end

  // Signal-loss watchdog.
  assign zeroTrip = netMode & (loss_check_interval_q == 14'h0000);
  assign lossTrip = lossRun_q & (lossCnt_q >= loss_check_interval_q) &
                    (loss_check_interval_q != `SLES_OFF_VALUE);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      netMode_q   <= 1'b0;
      lossArmed_q <= 1'b0;
      lossRun_q   <= 1'b0;
    end else begin
      netMode_q <= netMode;
      if (!netMode || loss_check_interval_q == `SLES_OFF_VALUE) begin
        lossArmed_q <= 1'b0;
        lossRun_q   <= 1'b0;
      end else if (netMode & ~netMode_q) begin
        lossArmed_q <= 1'b1;
        lossRun_q   <= 1'b0;
      end else if (lossArmed_q & reqDone) begin
        lossArmed_q <= 1'b0;
        lossRun_q   <= 1'b1;
      end
    end
  end

  // The count steps in tenths of a second; any request, whatever station, restarts it.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tick_q    <= 32'h00000000;
      lossCnt_q <= 14'h0000;
    end else if (!lossRun_q || reqDone) begin
      tick_q    <= 32'h00000000;
      lossCnt_q <= 14'h0000;
    end else if (tick_q == 32'(LOSS_STEP_CYC - 1)) begin
      tick_q    <= 32'h00000000;
      lossCnt_q <= (lossCnt_q == 14'h3FFF) ? lossCnt_q : lossCnt_q + 14'h0001;
    end else begin
      tick_q <= tick_q + 32'h00000001;
    end
  end

  // Fault and alarm are sticky; a new event in the clearing cycle wins.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      trip_q <= 1'b0;
    end else if ((reqDone & overLimit & ~retryOff) | lossTrip | zeroTrip) begin
      trip_q <= 1'b1;
    end else if (clrTrip) begin
      trip_q <= 1'b0;
    end
  end

  // Codes 7 and A to C never reach this flag, so they raise no alarm.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      alarm_q <= 1'b0;
    end else if ((reqDone & lineErr) | lossTrip | zeroTrip) begin
      alarm_q <= 1'b1;
    end else if (clrAlarm) begin
      alarm_q <= 1'b0;
    end
  end

  assign comm_fault_trip = trip_q;
  assign driveEnable     = ~trip_q;
  assign alarm_output    = alarm_q;

  // Terminal polarity follows its function setting; other settings leave it low.
  always_comb begin
    if (output_terminal_function_q == `SLES_TERM_POS) begin
      alarmTerminal = alarm_q;
    end else if (output_terminal_function_q == `SLES_TERM_NEG) begin
      alarmTerminal = ~alarm_q;
    end else begin
      alarmTerminal = 1'b0;
    end
  end

endmodule // sles_supervisor

// [sles_supervisor_asserts.sv]
// Concurrent checks on the ports of the link error supervisor.
`timescale 1ns/1ps
module sles_checker (
  // Clock and reset.
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  // Requests and drive state.
  input wire logic                 reqDone,
  input wire sles_pkg::slesReq_s   reqInfo,
  input wire logic                 linkActive,
  input wire logic                 cmdFromComm,
  input wire logic                 driveRunning,
  // Replies and faults.
  input wire logic                 replyValid,
  input wire sles_pkg::slesReply_s replyHead,
  input wire logic                 comm_fault_trip,
  input wire logic                 driveEnable,
  input wire logic                 alarm_output
);
  logic lineErr;
  logic modeBad;
  assign lineErr = reqInfo.parityErr | reqInfo.sumErr | reqInfo.protoErr | reqInfo.framingErr
                   | reqInfo.overrunErr;
  assign modeBad = reqInfo.paramWrite & (!linkActive | !cmdFromComm | driveRunning);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_line;
    reqDone && lineErr;
  endsequence
  sequence s_soft;
    reqDone && !lineErr && !reqInfo.charErr;
  endsequence
  a_reply_next: assert property (reqDone |=> replyValid)
    else $error("no reply after a request");
  a_nak_lead: assert property (s_line |=> replyHead.nak && replyHead.lead == 8'h15)
    else $error("line error answered without negative acknowledge");
  a_line_alarm: assert property (s_line |=> alarm_output)
    else $error("line error without alarm");
  a_parity_code: assert property (s_line ##0 (reqInfo.parityErr && !reqInfo.overrunErr &&
    !reqInfo.framingErr) |=> replyHead.codeChar inside {8'h30, 8'h31})
    else $error("parity error reported with a wrong code");
  a_char_hold: assert property (reqDone && reqInfo.charErr && !lineErr
    |=> replyHead.codeChar == 8'h37 && $stable(comm_fault_trip))
    else $error("character error code or trip wrong");
  a_mode_code: assert property (s_soft ##0 modeBad
    |=> replyHead.codeChar == 8'h41 && $stable(comm_fault_trip))
    else $error("mode error code or trip wrong");
  a_clean_ack: assert property (s_soft ##0 (!modeBad && !reqInfo.instrErr && !reqInfo.rangeErr)
    |=> !replyHead.nak && replyHead.lead == 8'h06 && replyHead.codeChar == 8'h46)
    else $error("clean request not acknowledged");
  a_drive_off: assert property (driveEnable != comm_fault_trip)
    else $error("drive enable does not follow the trip");
endmodule // sles_checker

bind sles_supervisor sles_checker chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .reqDone(reqDone), .reqInfo(reqInfo),
  .linkActive(linkActive), .cmdFromComm(cmdFromComm), .driveRunning(driveRunning),
  .replyValid(replyValid), .replyHead(replyHead), .comm_fault_trip(comm_fault_trip),
  .driveEnable(driveEnable), .alarm_output(alarm_output)
);

// [sles_host_model.sv]
// Behavioural host and frame receiver handing finished requests to the supervisor.
`timescale 1ns/1ps
module sles_host_model (
  // Clock.
  input  wire logic         sys_clk,
  // Finished requests.
  output logic              reqDone,
  output sles_pkg::slesReq_s reqInfo
);
  sles_pkg::slesReq_s held;
  sles_pkg::slesReq_s noise;
  // Between requests the flags toggle, so a stale request can never pass for a fresh one.
  assign reqInfo = reqDone ? held : noise;
  initial begin
    reqDone = 1'b0;
    held = 9'h000;
    noise = 9'h0AA;
  end
  always @(posedge sys_clk) begin
    noise <= ~noise;
  end
  // Requests arrive whole as finished flags; the characters and their framing bits are not modelled.
  // The wait sets how soon the host sends, within the loss interval or beyond it.
  task automatic send(input sles_pkg::slesReq_s info, input int waitCyc, input bit last);
    repeat (waitCyc) @(posedge sys_clk);
    reqDone <= 1'b1;
    held    <= info;
    @(posedge sys_clk);
    if (last) begin
      reqDone <= 1'b0;
    end
  endtask
endmodule // sles_host_model

// [sles_supervisor_test.sv]
// Self-checking bench for the link error supervisor with a behavioural host.
`timescale 1ns/1ps
module sles_supervisor_test;
  localparam int STEP = 20;
  logic                 sys_clk = 1'b0;
  logic                 reset_n;
  logic                 wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0]           wb_adr_i;
  logic [3:0]           wb_sel_i;
  logic [31:0]          wb_dat_i, wb_dat_o;
  logic                 reqDone, linkActive, cmdFromComm, driveRunning, netMode;
  sles_pkg::slesReq_s   reqInfo;
  sles_pkg::slesLineCfg_s lineCfg;
  logic [5:0]           fmt;
  sles_pkg::slesReply_s replyHead;
  logic                 replyValid, comm_fault_trip, driveEnable, alarm_output, alarmTerminal;
  logic [31:0]          repQ[$];
  logic [31:0]          rdQ[$];
  int                   numErrors = 0;
  int                   checks = 0;
  always #5 sys_clk = ~sys_clk;
  sles_supervisor #(.LOSS_STEP_CYC(STEP)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reqDone(reqDone), .reqInfo(reqInfo),
    .lineCfg(lineCfg), .linkActive(linkActive), .cmdFromComm(cmdFromComm),
    .driveRunning(driveRunning), .netMode(netMode), .replyValid(replyValid),
    .replyHead(replyHead), .comm_fault_trip(comm_fault_trip), .driveEnable(driveEnable),
    .alarm_output(alarm_output), .alarmTerminal(alarmTerminal));
  sles_host_model host_u (.sys_clk(sys_clk), .reqDone(reqDone), .reqInfo(reqInfo));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (numErrors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // The master waits for ack and checks it comes on the second edge; only the watchdog bounds a hang.
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    check("bus ack latency", 2, n);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] adr, input logic [31:0] exp);
    rdQ.push_back(exp);
    wb(1'b0, adr, 32'h0);
  endtask
  task automatic req(input logic [8:0] i, input logic [7:0] code, input logic trip,
                     input logic alarm, input int gap, input bit last);
    repQ.push_back({code != 8'h46, (code == 8'h46) ? 8'h06 : 8'h15, code, trip, alarm});
    host_u.send(i, (gap < 0) ? 1 + $urandom_range(2) : gap, last);
  endtask
  always @(posedge sys_clk) begin
    if (replyValid === 1'b1) begin
      if (repQ.size() == 0) check("reply count", 0, 1);
      else check("reply", repQ.pop_front(), {replyHead, comm_fault_trip, alarm_output});
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rdQ.size() == 0) check("read count", 0, 1);
      else check("read data", rdQ.pop_front(), wb_dat_o);
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    numErrors++;
    print_verdict();
  end
  initial begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {linkActive, cmdFromComm, driveRunning, netMode} = 4'hC;
    wb_sel_i = 4'hF;
    void'($urandom(1114));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(5'h00, 32'h0C);
    check("line format reset", 32'h0C, lineCfg);
    rd(5'h04, 32'h0);
    rd(5'h08, 32'h270F);
    rd(5'h0C, 32'h0);
    wb(1'b1, 5'h14, 32'hFFFFFFFF);
    rd(5'h14, 32'h0);
    fmt = 6'($urandom());
    wb(1'b1, 5'h00, {26'h0, fmt});
    rd(5'h00, {26'h0, fmt});
    check("line format", {fmt[0], fmt[1], fmt[2], fmt[3], fmt[5:4]}, lineCfg);
    wb(1'b1, 5'h04, 32'h3);
    for (int i = 0; i < 5; i++) begin
      req(9'h080 >> i, 8'h31 + i[7:0], 0, 1, -1, 1);
      req(9'h000, 8'h46, 0, 1, -1, 1);
    end
    for (int i = 0; i < 3; i++) begin
      req(9'h004 >> i, (i == 0) ? 8'h37 : 8'h41 + i[7:0], 0, 1, -1, 1);
    end
    for (int i = 0; i < 3; i++) begin
      linkActive   <= (i != 0);
      cmdFromComm  <= (i != 1);
      driveRunning <= (i == 2);
      req(9'h100, 8'h41, 0, 1, -1, 1);
    end
    {linkActive, cmdFromComm, driveRunning} <= 3'h6;
    req(9'h100, 8'h46, 0, 1, -1, 1);
    req(9'h088, 8'h35, 0, 1, -1, 1);
    req(9'h000, 8'h46, 0, 1, -1, 1);
    req(9'h080, 8'h31, 0, 1, -1, 0);
    req(9'h080, 8'h31, 0, 1, 0, 0);
    req(9'h004, 8'h37, 0, 1, 0, 0);
    req(9'h080, 8'h31, 0, 1, 0, 0);
    req(9'h080, 8'h30, 1, 1, 0, 1);
    repeat (2) @(posedge sys_clk);
    check("drive enable", 0, driveEnable);
    rd(5'h10, 32'h403);
    wb(1'b1, 5'h00, 32'hCC);
    req(9'h000, 8'h46, 0, 0, -1, 1);
    wb(1'b1, 5'h04, 32'h270F);
    for (int i = 0; i < 5; i++) req(9'h080, 8'h31, 0, 1, -1, 1);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 5'h0C, (i == 0) ? 32'h62 : (i == 1) ? 32'hC6 : 32'h11);
      check("alarm terminal", (i == 0), alarmTerminal);
    end
    wb(1'b1, 5'h00, 32'hCC);
    wb(1'b1, 5'h08, 32'h2);
    netMode <= 1'b1;
    repeat (100) @(posedge sys_clk);
    check("trip before start", 0, comm_fault_trip);
    for (int i = 0; i < 3; i++) req(9'h000, 8'h46, 0, 0, 30, 1);
    repeat (80) @(posedge sys_clk);
    check("loss trip", 3, {comm_fault_trip, alarm_output});
    wb(1'b1, 5'h08, 32'h270F);
    wb(1'b1, 5'h00, 32'hCC);
    repeat (100) @(posedge sys_clk);
    check("loss off", 0, comm_fault_trip);
    netMode <= 1'b0;
    wb(1'b1, 5'h08, 32'h0);
    check("zero interval idle", 0, comm_fault_trip);
    netMode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("zero interval trip", 1, comm_fault_trip);
    req(9'h000, 8'h46, 1, 1, -1, 1);
    repeat (5) @(posedge sys_clk);
    check("pending notes", 0, repQ.size() + rdQ.size());
    print_verdict();
  end
endmodule // sles_supervisor_test
